/* common/hee_regs.vh */
// register map, field positions and reset values of the event register bank
`ifndef HEE_REGS_VH
`define HEE_REGS_VH

// ****************************************
// register offsets
// ****************************************
`define HEE_AW           12
`define HEE_OFF_EXP_A    12'h354
`define HEE_OFF_EXP_B    12'h358
`define HEE_OFF_CTL      12'h35c
`define HEE_OFF_STS      12'h360
`define HEE_OFF_IRQ_STS  12'h364
`define HEE_OFF_IRQ_MSK  12'h368
`define HEE_OFF_INIT     12'h36c
`define HEE_OFF_AUX      12'h370

// ****************************************
// field positions
// ****************************************
`define HEE_EXP0_MSB     7
`define HEE_EXP0_LSB     1
`define HEE_EXP1_MSB     15
`define HEE_EXP1_LSB     9
`define HEE_EXP2_MSB     23
`define HEE_EXP2_LSB     17
`define HEE_EXP4_MSB     7
`define HEE_EXP4_LSB     1
`define HEE_CTL_INV      0
`define HEE_CTL_RDR_MSB  5
`define HEE_CTL_RDR_LSB  2
`define HEE_STS_PND_MSB  4
`define HEE_STS_PND_LSB  1
`define HEE_INIT_SEL_MSB 2
`define HEE_INIT_SEL_LSB 0
`define HEE_INIT_DONE    31
`define HEE_AUX_ALT      0
`define HEE_IRQ_DONE     0
`define HEE_IRQ_PRT_MSB  4
`define HEE_IRQ_PRT_LSB  1

// ****************************************
// select codes and reset values
// ****************************************
`define HEE_SEL_E0       3'h0
`define HEE_SEL_E1       3'h1
`define HEE_SEL_E2       3'h2
`define HEE_SEL_E4       3'h4
`define HEE_ADDR_RST     7'h00
`define HEE_RDR_RST      4'h0
`define HEE_SEL_RST      3'h0
`define HEE_IRQ_RST      5'h00
`define HEE_ZERO32       32'h0000_0000

`endif

/* hw/hee_port_event.v */
// per-port event redirection: suppresses notifications, raises pending
`timescale 1ns/1ps
module hee_port_event (
  input  wire clk,          // core clock
  input  wire arst_n,       // async reset, active low
  input  wire redirect,     // port event redirect enable
  input  wire event_req,    // port has a hot-plug or pm event pending
  input  wire intx_in,      // interrupt notification request
  input  wire msi_in,       // msi notification request
  input  wire pme_in,       // pm notification request
  output reg  intx_out,     // interrupt request passed on
  output reg  msi_out,      // msi request passed on
  output reg  pme_out,      // pm request passed on
  output reg  pending,      // port signalling on the shared event
  output reg  pending_rise  // one-cycle pulse when pending sets
);

  wire pending_next;

  assign pending_next = redirect & event_req;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intx_out     <= 1'b0;
      msi_out      <= 1'b0;
      pme_out      <= 1'b0;
      pending      <= 1'b0;
      pending_rise <= 1'b0;
    end else begin
      intx_out     <= intx_in & ~redirect;
      msi_out      <= msi_in & ~redirect;
      pme_out      <= pme_in & ~redirect;
      pending      <= pending_next;
      pending_rise <= pending_next & ~pending;
    end
  end

endmodule

/* hw/hee_init_track.v */
// tracks one expander initialization sequence from start to completion
`timescale 1ns/1ps
module hee_init_track (
  input  wire clk,       // core clock
  input  wire arst_n,    // async reset, active low
  input  wire start,     // address field written
  input  wire done_in,   // sequencer reports completion
  output reg  busy,      // sequence outstanding
  output wire done_evt   // completion of an outstanding sequence
);

  // completion without a started sequence is ignored
  assign done_evt = done_in & busy;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (done_in) begin
      busy <= 1'b0;
    end
  end

endmodule

/* hw/hee_top.v */
// event redirection and expander address register bank, top level
//
// Contract
// - first address register holds expanders 0,1,2 in bits 7:1, 15:9, 23:17.
// - second address register holds expander 4 address in bits 7:1 only.
// - polarity bit: clear gives active-low pin 7 output, set gives active-high.
// - port 2 redirect suppresses its notifications, uses shared event output.
// - port 3 redirect suppresses its notifications, uses shared event output.
// - port 4 redirect suppresses its notifications, uses shared event output.
// - port 5 redirect suppresses its notifications, uses shared event output.
// - shared event drives pin 7 only in its alternate function.
// - status bits 1..4 read one while ports 2..5 signal an event.
// - a port status bit never sets unless its redirect bit is set.
// - address write starts init; done flag sets when selected one completes.
`timescale 1ns/1ps
`include "hee_regs.vh"
module hee_top (
  input  wire                clk,            // core clock, 125 MHz
  input  wire                arst_n,         // async reset, active low
  input  wire [`HEE_AW-1:0]  reg_addr,       // register byte address
  input  wire [31:0]         reg_wdata,      // write data
  input  wire                reg_wr,         // write strobe
  input  wire                reg_rd,         // read strobe
  output reg  [31:0]         reg_rdata,      // read data, cycle after rd
  input  wire [3:0]          port_event_req, // ports 5..2 event pending
  input  wire [3:0]          port_intx_in,   // ports 5..2 interrupt req
  input  wire [3:0]          port_msi_in,    // ports 5..2 msi req
  input  wire [3:0]          port_pme_in,    // ports 5..2 pm req
  output wire [3:0]          port_intx_out,  // interrupt req passed on
  output wire [3:0]          port_msi_out,   // msi req passed on
  output wire [3:0]          port_pme_out,   // pm req passed on
  output wire [6:0]          exp0_bus_addr,  // expander 0 bus address
  output wire [6:0]          exp1_bus_addr,  // expander 1 bus address
  output wire [6:0]          exp2_bus_addr,  // expander 2 bus address
  output wire [6:0]          exp4_bus_addr,  // expander 4 bus address
  output reg  [3:0]          exp_init_start, // start init, 4,2,1,0
  input  wire [3:0]          exp_init_done,  // init complete, 4,2,1,0
  output wire [3:0]          exp_init_busy,  // init outstanding
  output reg                 shared_event_out, // event, active high
  output reg                 gpio7_out,      // pin 7 level
  output reg                 gpio7_oe,       // pin 7 driven
  output wire                irq             // level interrupt
);

  // ****************************************
  // registers
  // ****************************************
  reg  [6:0] expander_zero_bus_addr_reg;
  reg  [6:0] expander_one_bus_addr_reg;
  reg  [6:0] expander_two_bus_addr_reg;
  reg  [6:0] expander_four_bus_addr_reg;
  reg        event_polarity_invert_reg;
  reg  [3:0] port_event_redirect_reg;
  reg  [2:0] init_select_reg;
  reg        init_done_reg;
  reg        init_done_next;
  reg        gpio_alt_reg;
  reg  [4:0] irq_sts_reg;
  reg  [4:0] irq_sts_next;
  reg  [4:0] irq_msk_reg;
  reg  [31:0] rdata_next;

  // ****************************************
  // internal signals
  // ****************************************
  wire       wr_exp_a;
  wire       wr_exp_b;
  wire       wr_ctl;
  wire       wr_irq_sts;
  wire       wr_irq_msk;
  wire       wr_init;
  wire       wr_aux;
  wire [3:0] port_event_pending;
  wire [3:0] pending_rise;
  wire [3:0] init_start_w;
  wire [3:0] init_evt;
  wire [3:0] sel_match;
  wire       done_set;
  wire [4:0] irq_set;
  wire       shared_event_next;
  wire       pin_level_next;

  // ****************************************
  // write decode
  // ****************************************
  assign wr_exp_a   = reg_wr & (reg_addr == `HEE_OFF_EXP_A);
  assign wr_exp_b   = reg_wr & (reg_addr == `HEE_OFF_EXP_B);
  assign wr_ctl     = reg_wr & (reg_addr == `HEE_OFF_CTL);
  assign wr_irq_sts = reg_wr & (reg_addr == `HEE_OFF_IRQ_STS);
  assign wr_irq_msk = reg_wr & (reg_addr == `HEE_OFF_IRQ_MSK);
  assign wr_init    = reg_wr & (reg_addr == `HEE_OFF_INIT);
  assign wr_aux     = reg_wr & (reg_addr == `HEE_OFF_AUX);

  // ****************************************
  // expander address registers
  // ****************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      expander_zero_bus_addr_reg <= `HEE_ADDR_RST;
      expander_one_bus_addr_reg  <= `HEE_ADDR_RST;
      expander_two_bus_addr_reg  <= `HEE_ADDR_RST;
    end else if (wr_exp_a) begin
      expander_zero_bus_addr_reg <=
        reg_wdata[`HEE_EXP0_MSB:`HEE_EXP0_LSB];
      expander_one_bus_addr_reg  <=
        reg_wdata[`HEE_EXP1_MSB:`HEE_EXP1_LSB];
      expander_two_bus_addr_reg  <=
        reg_wdata[`HEE_EXP2_MSB:`HEE_EXP2_LSB];
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      expander_four_bus_addr_reg <= `HEE_ADDR_RST;
    end else if (wr_exp_b) begin
      expander_four_bus_addr_reg <=
        reg_wdata[`HEE_EXP4_MSB:`HEE_EXP4_LSB];
    end
  end

  assign exp0_bus_addr = expander_zero_bus_addr_reg;
  assign exp1_bus_addr = expander_one_bus_addr_reg;
  assign exp2_bus_addr = expander_two_bus_addr_reg;
  assign exp4_bus_addr = expander_four_bus_addr_reg;

  // ****************************************
  // event control and configuration
  // ****************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      event_polarity_invert_reg <= 1'b0;
      port_event_redirect_reg   <= `HEE_RDR_RST;
    end else if (wr_ctl) begin
      event_polarity_invert_reg <= reg_wdata[`HEE_CTL_INV];
      port_event_redirect_reg   <=
        reg_wdata[`HEE_CTL_RDR_MSB:`HEE_CTL_RDR_LSB];
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gpio_alt_reg <= 1'b0;
    end else if (wr_aux) begin
      gpio_alt_reg <= reg_wdata[`HEE_AUX_ALT];
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      init_select_reg <= `HEE_SEL_RST;
    end else if (wr_init) begin
      init_select_reg <=
        reg_wdata[`HEE_INIT_SEL_MSB:`HEE_INIT_SEL_LSB];
    end
  end

  // ****************************************
  // per-port event redirection, ports 2..5
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_port
      hee_port_event u_port (
        .clk          (clk),
        .arst_n       (arst_n),
        .redirect     (port_event_redirect_reg[gi]),
        .event_req    (port_event_req[gi]),
        .intx_in      (port_intx_in[gi]),
        .msi_in       (port_msi_in[gi]),
        .pme_in       (port_pme_in[gi]),
        .intx_out     (port_intx_out[gi]),
        .msi_out      (port_msi_out[gi]),
        .pme_out      (port_pme_out[gi]),
        .pending      (port_event_pending[gi]),
        .pending_rise (pending_rise[gi])
      );
    end
  endgenerate

  // ****************************************
  // shared event output on pin 7
  // ****************************************
  assign shared_event_next = |port_event_pending;
  // deasserted level follows the polarity even when idle
  assign pin_level_next = event_polarity_invert_reg ?
                          shared_event_next :
                          ~shared_event_next;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shared_event_out <= 1'b0;
      gpio7_out        <= 1'b1;
      gpio7_oe         <= 1'b0;
    end else begin
      shared_event_out <= shared_event_next;
      gpio7_out        <= pin_level_next;
      gpio7_oe         <= gpio_alt_reg;
    end
  end

  // ****************************************
  // expander initialization tracking
  // ****************************************
  // a write to an address register restarts every field in it
  assign init_start_w = {wr_exp_b, wr_exp_a, wr_exp_a, wr_exp_a};

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      exp_init_start <= 4'h0;
    end else begin
      exp_init_start <= init_start_w;
    end
  end

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_init
      hee_init_track u_init (
        .clk      (clk),
        .arst_n   (arst_n),
        .start    (exp_init_start[gi]),
        .done_in  (exp_init_done[gi]),
        .busy     (exp_init_busy[gi]),
        .done_evt (init_evt[gi])
      );
    end
  endgenerate

  assign sel_match[0] = (init_select_reg == `HEE_SEL_E0);
  assign sel_match[1] = (init_select_reg == `HEE_SEL_E1);
  assign sel_match[2] = (init_select_reg == `HEE_SEL_E2);
  assign sel_match[3] = (init_select_reg == `HEE_SEL_E4);
  assign done_set     = |(init_evt & sel_match);

  // done flag: write one clears, a completion in the same cycle wins
  always @* begin
    init_done_next = init_done_reg;
    if (wr_init & reg_wdata[`HEE_INIT_DONE]) begin
      init_done_next = 1'b0;
    end
    if (done_set) begin
      init_done_next = 1'b1;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      init_done_reg <= 1'b0;
    end else begin
      init_done_reg <= init_done_next;
    end
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  assign irq_set = {pending_rise, done_set};

  always @* begin
    irq_sts_next = irq_sts_reg;
    if (wr_irq_sts) begin
      irq_sts_next = irq_sts_reg &
        ~reg_wdata[`HEE_IRQ_PRT_MSB:`HEE_IRQ_DONE];
    end
    irq_sts_next = irq_sts_next | irq_set;
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_sts_reg <= `HEE_IRQ_RST;
    end else begin
      irq_sts_reg <= irq_sts_next;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_msk_reg <= `HEE_IRQ_RST;
    end else if (wr_irq_msk) begin
      irq_msk_reg <= reg_wdata[`HEE_IRQ_PRT_MSB:`HEE_IRQ_DONE];
    end
  end

  assign irq = |(irq_sts_reg & irq_msk_reg);

  // ****************************************
  // read back
  // ****************************************
  always @* begin
    rdata_next = `HEE_ZERO32;
    case (reg_addr)
      `HEE_OFF_EXP_A: begin
        rdata_next[`HEE_EXP0_MSB:`HEE_EXP0_LSB] =
          expander_zero_bus_addr_reg;
        rdata_next[`HEE_EXP1_MSB:`HEE_EXP1_LSB] =
          expander_one_bus_addr_reg;
        rdata_next[`HEE_EXP2_MSB:`HEE_EXP2_LSB] =
          expander_two_bus_addr_reg;
      end
      `HEE_OFF_EXP_B: begin
        rdata_next[`HEE_EXP4_MSB:`HEE_EXP4_LSB] =
          expander_four_bus_addr_reg;
      end
      `HEE_OFF_CTL: begin
        rdata_next[`HEE_CTL_INV] = event_polarity_invert_reg;
        rdata_next[`HEE_CTL_RDR_MSB:`HEE_CTL_RDR_LSB] =
          port_event_redirect_reg;
      end
      `HEE_OFF_STS: begin
        rdata_next[`HEE_STS_PND_MSB:`HEE_STS_PND_LSB] =
          port_event_pending;
      end
      `HEE_OFF_IRQ_STS: begin
        rdata_next[`HEE_IRQ_PRT_MSB:`HEE_IRQ_DONE] = irq_sts_reg;
      end
      `HEE_OFF_IRQ_MSK: begin
        rdata_next[`HEE_IRQ_PRT_MSB:`HEE_IRQ_DONE] = irq_msk_reg;
      end
      `HEE_OFF_INIT: begin
        rdata_next[`HEE_INIT_SEL_MSB:`HEE_INIT_SEL_LSB] =
          init_select_reg;
        rdata_next[`HEE_INIT_DONE] = init_done_reg;
      end
      `HEE_OFF_AUX: begin
        rdata_next[`HEE_AUX_ALT] = gpio_alt_reg;
      end
      default: begin
        rdata_next = `HEE_ZERO32;
      end
    endcase
  end

  // data stands only in the cycle after the read strobe
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `HEE_ZERO32;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= `HEE_ZERO32;
    end
  end

endmodule

/* test/hee_monitor.sv */
// concurrent checks on the ports of the event register bank
`timescale 1ns/1ps
module hee_monitor (
  input logic        clk,              // core clock
  input logic        arst_n,           // async reset, active low
  input logic [11:0] reg_addr,         // register byte address
  input logic [31:0] reg_wdata,        // write data
  input logic        reg_wr,           // write strobe
  input logic        reg_rd,           // read strobe
  input logic [31:0] reg_rdata,        // read data
  input logic [3:0]  port_event_req,   // port event requests
  input logic [3:0]  port_intx_in,     // interrupt requests in
  input logic [3:0]  port_intx_out,    // interrupt requests out
  input logic [6:0]  exp0_bus_addr,    // expander 0 address
  input logic [3:0]  exp_init_start,   // init start pulses
  input logic        shared_event_out, // shared event, active high
  input logic        gpio7_out,        // pin 7 level
  input logic        gpio7_oe          // pin 7 driven
);
  // ****************************************
  // shadow of control bits seen on the bus
  // ****************************************
  logic [3:0] rdr_q;
  logic       inv_q;
  logic       alt_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdr_q <= 4'h0;
      inv_q <= 1'b0;
      alt_q <= 1'b0;
    end else if (reg_wr && reg_addr == 12'h35c) begin
      rdr_q <= reg_wdata[5:2];
      inv_q <= reg_wdata[0];
    end else if (reg_wr && reg_addr == 12'h370) begin
      alt_q <= reg_wdata[0];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_exp0_load: assert property (reg_wr && reg_addr == 12'h354 |=>
    exp0_bus_addr == $past(reg_wdata[7:1]))
    else $error("expander 0 address not loaded");
  a_addr_a_rsvd: assert property (reg_rd && reg_addr == 12'h354 |=>
    reg_rdata[31:24] == 8'h00 && !reg_rdata[16] && !reg_rdata[8]
    && !reg_rdata[0]) else $error("reserved bits set in address a");
  a_addr_b_rsvd: assert property (reg_rd && reg_addr == 12'h358 |=>
    reg_rdata[31:8] == 24'h0 && !reg_rdata[0])
    else $error("reserved bits set in address b");
  a_init_start: assert property (reg_wr && reg_addr == 12'h354 |=>
    exp_init_start[2:0] == 3'h7) else $error("init start missing");
  a_start_cause: assert property (exp_init_start[3] |->
    $past(reg_wr && reg_addr == 12'h358)) else $error("spurious start");
  a_pol_level: assert property (gpio7_out ==
    ($past(inv_q) ? shared_event_out : !shared_event_out))
    else $error("pin level polarity wrong");
  a_shared_or: assert property (shared_event_out ==
    |($past(rdr_q, 2) & $past(port_event_req, 2)))
    else $error("shared event not or of redirected events");
  a_notify_gate: assert property (port_intx_out ==
    $past(port_intx_in & ~rdr_q)) else $error("notification not gated");
  a_pin_off: assert property (!alt_q && !$past(alt_q) |-> !gpio7_oe)
    else $error("pin driven without alternate function");
  a_sts_masked: assert property (reg_rd && reg_addr == 12'h360 |=>
    (reg_rdata[4:1] & ~($past(rdr_q) | $past(rdr_q, 2))) == 4'h0
    && reg_rdata[31:5] == 27'h0 && !reg_rdata[0])
    else $error("status bit set without redirect");

  c_addr_wr: cover property (reg_wr && reg_addr == 12'h354);
  c_event: cover property ($rose(shared_event_out));
  c_sts_rd: cover property (reg_rd && reg_addr == 12'h360 ##1 reg_rdata != 0);
endmodule

bind hee_top hee_monitor u_mon (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .port_event_req(port_event_req), .port_intx_in(port_intx_in),
  .port_intx_out(port_intx_out), .exp0_bus_addr(exp0_bus_addr),
  .exp_init_start(exp_init_start), .shared_event_out(shared_event_out),
  .gpio7_out(gpio7_out), .gpio7_oe(gpio7_oe)
);

/* test/hee_exp_model.sv */
// expander bus sequencer model: answers each init start after a delay
`timescale 1ns/1ps
module hee_exp_model (
  input  logic       clk,    // core clock
  input  logic       arst_n, // async reset, active low
  input  logic       slow,   // long init sequences
  input  logic [3:0] start,  // init start per expander
  output logic [3:0] done    // init complete pulse
);
  int cnt [4];
  always @(posedge clk or negedge arst_n) begin
    for (int i = 0; i < 4; i++) begin
      if (!arst_n || start[i])
        cnt[i] <= arst_n ? (slow ? 37 : 3) : 0;
      else if (cnt[i] != 0)
        cnt[i] <= cnt[i] - 1;
      done[i] <= arst_n && !start[i] && cnt[i] == 1;
    end
  end
endmodule

/* test/hee_top_tb_top.sv */
// self-checking bench for the event register bank
`timescale 1ns/1ps
module hee_top_tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        slow = 1'b0;
  logic [3:0]  ev_req = 4'h0, intx_in = 4'h0, msi_in = 4'h0, pme_in = 4'h0;
  logic [31:0] reg_rdata, r, m_ea = 32'h0, m_eb = 32'h0;
  logic [3:0]  intx_out, msi_out, pme_out, start, done, busy, rdr, pe;
  logic [6:0]  e0, e1, e2, e4;
  logic        shared, g_out, g_oe, irq, inv, fl;
  logic [11:0] offs [9] = '{12'h354, 12'h358, 12'h35c, 12'h360, 12'h364,
                            12'h368, 12'h36c, 12'h370, 12'h3f0};
  logic [2:0]  sels [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
  int          miscompares = 0;
  int          n_tests = 0;

  hee_top uut (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_event_req(ev_req), .port_intx_in(intx_in), .port_msi_in(msi_in),
    .port_pme_in(pme_in), .port_intx_out(intx_out), .port_msi_out(msi_out),
    .port_pme_out(pme_out), .exp0_bus_addr(e0), .exp1_bus_addr(e1),
    .exp2_bus_addr(e2), .exp4_bus_addr(e4), .exp_init_start(start),
    .exp_init_done(done), .exp_init_busy(busy), .shared_event_out(shared),
    .gpio7_out(g_out), .gpio7_oe(g_oe), .irq(irq)
  );
  hee_exp_model u_exp (
    .clk(clk), .arst_n(arst_n), .slow(slow), .start(start), .done(done)
  );

  always #4 clk = ~clk;

  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 4'h0 && k < 200) begin
      cyc(1);
      k++;
    end
    if (k == 200) begin
      chk("init_busy_timeout", 32'h1, 32'h0);
      print_verdict();
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    void'($urandom(75763));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    cyc(1);
    chk("gpio7_out", g_out, 32'h1);
    chk("gpio7_oe", g_oe, 32'h0);
    foreach (offs[i]) rd(offs[i], 32'h0);
    $display("test reset values done");

    // address fields, init start and done flag per selected expander
    wr(12'h368, 32'h0000_0001);
    foreach (sels[j]) begin
      slow <= j[0];
      wr(12'h36c, {29'h0, sels[j]});
      r = $urandom();
      if (sels[j] == 3'h4)
        m_eb = r & 32'h0000_00fe;
      else
        m_ea = r & 32'h00fe_fefe;
      wr(sels[j] == 3'h4 ? 12'h358 : 12'h354, r);
      cyc(3);
      wait_idle();
      cyc(1);
      fl = (sels[j] != 3'h3);
      rd(12'h354, m_ea);
      rd(12'h358, m_eb);
      chk("exp_bus_addr", {e0, e1, e2, e4}, {m_ea[7:1], m_ea[15:9],
          m_ea[23:17], m_eb[7:1]});
      rd(12'h36c, {fl, 28'h0, sels[j]});
      chk("irq", irq, fl);
      wr(12'h36c, {1'b1, 28'h0, sels[j]});
      wr(12'h364, 32'h0000_0001);
      cyc(1);
      chk("irq", irq, 32'h0);
      rd(12'h36c, {29'h0, sels[j]});
    end
    $display("test expander init done");

    // every port, both polarities, then no redirect at all
    wr(12'h370, 32'h0000_0001);
    wr(12'h368, 32'h0000_001e);
    for (int k = 0; k < 9; k++) begin
      rdr = (k == 8) ? 4'h0 : 4'h1 << k[1:0];
      inv = k[2];
      wr(12'h35c, {26'h0, rdr, 1'b0, inv});
      r = $urandom();
      @(posedge clk);
      ev_req <= (k == 8) ? 4'hf : r[3:0] | rdr;
      intx_in <= r[7:4];
      msi_in <= r[11:8];
      pme_in <= r[15:12];
      cyc(3);
      pe = ev_req & rdr;
      chk("shared_event_out", shared, |pe);
      chk("gpio7_out", g_out, {31'h0, (|pe) ~^ inv});
      chk("gpio7_oe", g_oe, 32'h1);
      chk("notify_out", {intx_out, msi_out, pme_out},
          {r[7:4] & ~rdr, r[11:8] & ~rdr, r[15:12] & ~rdr});
      rd(12'h360, {27'h0, pe, 1'b0});
      chk("irq", irq, |pe);
      @(posedge clk);
      ev_req <= 4'h0;
      cyc(3);
      chk("gpio7_out", g_out, !inv);
      wr(12'h364, 32'h0000_001f);
      cyc(1);
      chk("irq", irq, 32'h0);
    end
    // masked port event: status sets, interrupt stays low
    wr(12'h368, 32'h0000_0000);
    wr(12'h35c, 32'h0000_0004);
    @(posedge clk);
    ev_req <= 4'h1;
    cyc(3);
    chk("irq", irq, 32'h0);
    rd(12'h364, 32'h0000_0002);
    $display("test event redirect done");
    print_verdict();
  end
endmodule
